// ==== rtl/eeprom_ctrl_pkg.sv ====
// Constants, types and command tables for the EEPROM host controller
`default_nettype none
package eeprom_ctrl_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int WE_GLITCH_NS = 5;
    localparam int WE_LOW_CYC = (WE_GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_ACCESS_NS = 256;
    localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int BYTE_LOAD_WINDOW_US = 100;
    localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * 1000 / CLK_NS;
    localparam int PAGE_LOAD_TIMEOUT_US = 200;
    localparam int PAGE_LOAD_TIMEOUT_CYC =
        (PAGE_LOAD_TIMEOUT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int STABLE_READS = 3;
    // ------------------------------------------------------------------
    // Command series codes
    // ------------------------------------------------------------------
    localparam logic [15:0] CMD_ADDR1 = 16'h5555;
    localparam logic [15:0] CMD_ADDR2 = 16'h2AAA;
    localparam logic [7:0] UNLOCK_1 = 8'hAA;
    localparam logic [7:0] UNLOCK_2 = 8'h55;
    localparam logic [7:0] CMD_WRITE = 8'hA0;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_GUARD_OFF = 8'h20;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ADDR = 12'h004;
    localparam logic [11:0] OFS_WDATA = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_GUARD = 2;
    localparam int ST_ID = 3;
    localparam int ST_RDATA = 8;
    typedef enum logic [2:0] {
        OP_READ, OP_PROT_WRITE, OP_PLAIN_WRITE, OP_GUARD_OFF,
        OP_ID_ENTRY, OP_ID_EXIT
    } op_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pins_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } load_t;
    localparam pins_t PINS_IDLE = '{16'h0000, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};

    // Number of byte loads that an operation issues
    function automatic logic [2:0] seq_len(op_t op);
        case (op)
            OP_PROT_WRITE: return 3'h4;
            OP_PLAIN_WRITE: return 3'h1;
            OP_GUARD_OFF: return 3'h6;
            OP_ID_ENTRY, OP_ID_EXIT: return 3'h3;
            default: return 3'h0;
        endcase
    endfunction : seq_len

    // Address and data of byte load idx of an operation
    function automatic load_t seq_load(op_t op, logic [2:0] idx,
                                       logic [15:0] ua, logic [7:0] ud);
        load_t l;
        l.addr = CMD_ADDR1;
        l.data = UNLOCK_1;
        case (idx)
            3'h1, 3'h4: begin
                l.addr = CMD_ADDR2;
                l.data = UNLOCK_2;
            end
            3'h2: begin
                case (op)
                    OP_PROT_WRITE: l.data = CMD_WRITE;
                    OP_GUARD_OFF: l.data = CMD_SETUP;
                    OP_ID_ENTRY: l.data = CMD_ID_ENTRY;
                    default: l.data = CMD_ID_EXIT;
                endcase
            end
            3'h5: l.data = CMD_GUARD_OFF;
            default: ;
        endcase
        if (op == OP_PLAIN_WRITE || (op == OP_PROT_WRITE && idx == 3'h3)) begin
            l.addr = ua;
            l.data = ud;
        end
        return l;
    endfunction : seq_load
endpackage : eeprom_ctrl_pkg
`default_nettype wire

// ==== rtl/eeprom_host_ctrl.sv ====
// APB-programmed host controller that drives a page-write EEPROM
//
// Local design decisions: the register addresses and the APB interface to the registers.
`default_nettype none
module eeprom_host_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int PAGE_WAIT_CYC = PAGE_LOAD_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output pins_t pins,
    input wire logic [7:0] dq_in
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_WLOW, S_HOLD, S_WAIT, S_READ, S_GAP
    } state_t;
    state_t state_reg, state_next;
    op_t op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [1:0] stable_reg, stable_next;
    logic prev_tog_reg, prev_tog_next;
    logic first_reg, first_next;
    logic polling_reg, polling_next;
    logic guard_reg, guard_next;
    logic id_reg, id_next;
    logic [7:0] rdata_reg, rdata_next;
    pins_t pins_reg, pins_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic done_reg, done_next;
    logic [31:0] prdata_reg, prdata_next;
    logic access, start, finish, mapped, valid_read;
    load_t cur_load;
    logic [15:0] read_addr;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign access = psel && penable;
    assign mapped = paddr == OFS_CTRL || paddr == OFS_ADDR
        || paddr == OFS_WDATA || paddr == OFS_STATUS;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_reg;
    // Orders are taken only while idle so a running series stays intact
    assign start = access && pwrite && paddr == OFS_CTRL
        && state_reg == S_IDLE;

    // Register writes, sticky done flag and read data captured at setup
    always_comb begin
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        done_next = done_reg;
        prdata_next = prdata_reg;
        if (access && pwrite && state_reg == S_IDLE) begin
            if (paddr == OFS_ADDR) begin
                addr_next = pwdata[15:0];
            end
            if (paddr == OFS_WDATA) begin
                wdata_next = pwdata[7:0];
            end
        end
        if (access && pwrite && paddr == OFS_STATUS && pwdata[ST_DONE]) begin
            done_next = 1'b0;
        end
        if (finish) begin
            done_next = 1'b1; // Set beats a clear in the same cycle
        end
        if (psel && !penable) begin
            prdata_next = '0;
            case (paddr)
                OFS_CTRL: prdata_next[2:0] = op_reg;
                OFS_ADDR: prdata_next[15:0] = addr_reg;
                OFS_WDATA: prdata_next[7:0] = wdata_reg;
                OFS_STATUS: begin
                    prdata_next[ST_BUSY] = state_reg != S_IDLE;
                    prdata_next[ST_DONE] = done_reg;
                    prdata_next[ST_GUARD] = guard_reg;
                    prdata_next[ST_ID] = id_reg;
                    prdata_next[ST_RDATA +: 8] = rdata_reg;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            done_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            done_reg <= done_next;
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------------
    assign cur_load = seq_load(op_next, step_next, addr_reg, wdata_reg);
    // Disable series has no user byte, so poll the command address
    // Next op, so the first read cycle of a new order already has it
    assign read_addr = (op_next == OP_GUARD_OFF) ? CMD_ADDR1 : addr_reg;
    // Poll bit must match bit 7 of the written byte, except in the disable series, and the toggle bit must stop moving
    assign valid_read = first_reg && dq_in[TOGGLE_BIT] == prev_tog_reg
        && (op_reg == OP_GUARD_OFF || dq_in[POLL_BIT] == wdata_reg[POLL_BIT]);
    assign finish = (state_reg == S_HOLD && step_reg == seq_len(op_reg) - 3'h1
            && (op_reg == OP_ID_ENTRY || op_reg == OP_ID_EXIT))
        || (state_reg == S_READ && cnt_reg == 16'(READ_CYC - 1)
            && (!polling_reg || stable_next == 2'(STABLE_READS)));

    // Next state of the sequencer and the pins it drives
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        cnt_next = cnt_reg + 16'h0001;
        stable_next = stable_reg;
        prev_tog_next = prev_tog_reg;
        first_next = first_reg;
        polling_next = polling_reg;
        guard_next = guard_reg;
        id_next = id_reg;
        rdata_next = rdata_reg;
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    op_next = op_t'(pwdata[2:0]);
                    step_next = 3'h0;
                    cnt_next = 16'h0000;
                    polling_next = 1'b0;
                    first_next = 1'b0;
                    stable_next = 2'h0;
                    state_next = (seq_len(op_t'(pwdata[2:0])) == 3'h0)
                        ? S_READ : S_SETUP;
                end
            end
            S_SETUP: begin
                cnt_next = 16'h0000;
                state_next = S_WLOW;
            end
            S_WLOW: begin
                // Strobe held past the glitch filter width
                if (cnt_reg == 16'(WE_LOW_CYC - 1)) begin
                    state_next = S_HOLD;
                end
            end
            S_HOLD: begin
                cnt_next = 16'h0000;
                if (step_reg != seq_len(op_reg) - 3'h1) begin
                    step_next = step_reg + 3'h1;
                    state_next = S_SETUP;
                end else if (op_reg == OP_ID_ENTRY) begin
                    id_next = 1'b1;
                    state_next = S_IDLE;
                end else if (op_reg == OP_ID_EXIT) begin
                    id_next = 1'b0;
                    state_next = S_IDLE;
                end else begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                // Stay off the pins so the page load times out
                if (cnt_reg == 16'(PAGE_WAIT_CYC - 1)) begin
                    cnt_next = 16'h0000;
                    polling_next = 1'b1;
                    state_next = S_READ;
                end
            end
            S_READ: begin
                if (cnt_reg == 16'(READ_CYC - 1)) begin
                    rdata_next = dq_in;
                    prev_tog_next = dq_in[TOGGLE_BIT];
                    first_next = 1'b1;
                    // A match is trusted only after two more valid reads
                    stable_next = valid_read ? stable_reg + 2'h1 : 2'h0;
                    state_next = S_GAP;
                    // Same test as finish, kept local to avoid a comb loop
                    if (!polling_reg || stable_next == 2'(STABLE_READS)) begin
                        state_next = S_IDLE;
                        if (op_reg == OP_PROT_WRITE) begin
                            guard_next = 1'b1;
                        end
                        if (op_reg == OP_GUARD_OFF) begin
                            guard_next = 1'b0;
                        end
                    end
                end
            end
            S_GAP: begin
                cnt_next = 16'h0000;
                state_next = S_READ;
            end
            default: state_next = S_IDLE;
        endcase
        // Pins follow the next state so they leave straight from flops
        pins_next = PINS_IDLE;
        pins_next.addr = pins_reg.addr;
        case (state_next)
            S_SETUP, S_WLOW, S_HOLD: begin
                pins_next.addr = cur_load.addr;
                pins_next.dq_out = cur_load.data;
                pins_next.dq_oe = 1'b1;
                pins_next.ce_n = 1'b0;
                pins_next.we_n = state_next != S_WLOW;
            end
            S_READ: begin
                pins_next.addr = read_addr;
                pins_next.ce_n = 1'b0;
                pins_next.oe_n = 1'b0;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            op_reg <= OP_READ;
            step_reg <= 3'h0;
            cnt_reg <= 16'h0000;
            stable_reg <= 2'h0;
            prev_tog_reg <= 1'b0;
            first_reg <= 1'b0;
            polling_reg <= 1'b0;
            guard_reg <= 1'b0;
            id_reg <= 1'b0;
            rdata_reg <= 8'h00;
            pins_reg <= PINS_IDLE;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            stable_reg <= stable_next;
            prev_tog_reg <= prev_tog_next;
            first_reg <= first_next;
            polling_reg <= polling_next;
            guard_reg <= guard_next;
            id_reg <= id_next;
            rdata_reg <= rdata_next;
            pins_reg <= pins_next;
        end
    end
    assign pins = pins_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_we_pulse;
        $fell(pins_reg.we_n) ##1 $rose(pins_reg.we_n);
    endsequence
    sequence s_unlock_pair;
        pins_reg.addr == CMD_ADDR1 && pins_reg.dq_out == UNLOCK_1 && 
        !pins_reg.we_n ##2 pins_reg.addr == CMD_ADDR2 &&
        pins_reg.dq_out == UNLOCK_2;
    endsequence

    property p_write_inhibit;
        !pins_reg.we_n |-> !pins_reg.ce_n && pins_reg.oe_n;
    endproperty
    a_write_inhibit: assert property (p_write_inhibit)
        else $error("strobe low while output enabled or deselected");
    property p_dq_release;
        !pins_reg.oe_n |-> !pins_reg.dq_oe;
    endproperty
    a_dq_release: assert property (p_dq_release)
        else $error("data driven during read");
    property p_we_pulse;
        $fell(pins_reg.we_n) |-> s_we_pulse;
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write strobe width wrong");
    property p_unlock_start;
        state_reg == S_WLOW && step_reg == 3'h0 && op_reg != OP_PLAIN_WRITE
        |-> s_unlock_pair;
    endproperty
    a_unlock_start: assert property (p_unlock_start)
        else $error("unlock pair malformed");
    property p_page_byte;
        state_reg == S_SETUP && op_reg == OP_PROT_WRITE && step_reg == 3'h3
        |-> pins_reg.addr == addr_reg && pins_reg.dq_out == wdata_reg;
    endproperty
    a_page_byte: assert property (p_page_byte)
        else $error("page byte not loaded after unlock");
    property p_quiet_wait;
        $rose(state_reg == S_WAIT) |-> pins_reg.ce_n [*8];
    endproperty
    a_quiet_wait: assert property (p_quiet_wait)
        else $error("pins touched during load timeout");
    property p_guard_clear;
        $fell(guard_reg) |-> $past(op_reg) == OP_GUARD_OFF
            && $past(step_reg) == 3'h5;
    endproperty
    a_guard_clear: assert property (p_guard_clear)
        else $error("guard cleared without six loads");
    property p_id_change;
        $changed(id_reg) |-> $past(op_reg) == (id_reg ? OP_ID_ENTRY
            : OP_ID_EXIT) && $past(step_reg) == 3'h2;
    endproperty
    a_id_change: assert property (p_id_change)
        else $error("identification mode changed without command");
    property p_confirm;
        finish && polling_reg |-> stable_reg == 2'(STABLE_READS - 1);
    endproperty
    a_confirm: assert property (p_confirm)
        else $error("write declared done without confirming reads");
endmodule : eeprom_host_ctrl
`default_nettype wire

// ==== tb/eeprom_dev_model.sv ====
// Behavioural model of the page-write EEPROM on the controller's pins
`default_nettype none
module eeprom_dev_model
    import eeprom_ctrl_pkg::*;
#(
    parameter int LOAD_WAIT = 10,
    parameter int WRITE_CYC = 100,
    parameter int LOCK_CYC = 60,
    parameter logic [7:0] MAKER_ID = 8'h4E, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'hC3 // Arbitrary value
) (
    input wire logic clock,
    input wire pins_t pins,
    output logic [7:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // State; no reset pin, so it outlives controller resets
    // ------------------------------------------------------------------
    logic [7:0] mem [65536];
    logic [15:0] pa [$];
    logic [7:0] pd [$];
    logic [15:0] last_a = 16'h0000;
    logic [7:0] last_d = 8'h00;
    logic [7:0] rv = 8'h00;
    logic guard = 1'b0; // Shipped unguarded
    logic id_mode = 1'b0;
    logic armed = 1'b0;
    logic tog = 1'b0;
    logic we_was = 1'b1;
    logic oe_was = 1'b1;
    int step = 0, idle = 0, busy = 0, lock = 0, low = 0;

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        dq_in = 8'h00;
    end

    // Whether a load is the expected one at a step of a series
    function automatic logic fits(int s, logic [15:0] a, logic [7:0] d);
        if (s == 1 || s == 4) return a == CMD_ADDR2 && d == UNLOCK_2;
        if (s == 2) return a == CMD_ADDR1 && d inside
            {CMD_WRITE, CMD_SETUP, CMD_ID_ENTRY, CMD_ID_EXIT};
        return a == CMD_ADDR1 && d == (s == 5 ? CMD_GUARD_OFF : UNLOCK_1);
    endfunction : fits

    // One latched byte load
    task automatic take(input logic [15:0] a, input logic [7:0] d);
        if (step != 0 && !fits(step, a, d)) step = 0;
        if (fits(step, a, d)) begin
            if (step == 2 && d != CMD_SETUP) begin
                guard |= (d == CMD_WRITE); // One flag
                armed = (d == CMD_WRITE);
                if (d == CMD_ID_ENTRY) id_mode = 1'b1;
                if (d == CMD_ID_EXIT) id_mode = 1'b0;
                step = 0;
            end else if (step == 5) begin
                guard = 1'b0; // Only the full series
                step = 0;
                busy = WRITE_CYC;
                tog = 1'b0;
                last_d = d;
            end else begin
                step++;
            end
        end else if (guard && !armed) begin
            lock = LOCK_CYC; // Dropped, device locked
            pa.delete();
            pd.delete();
        end else begin
            pa.push_back(a);
            pd.push_back(d);
            last_a = a;
            last_d = d;
            idle = LOAD_WAIT; // Page stays open
        end
    endtask : take

    // Strobe decode, page timer, reads; a released bus never holds data
    always @(posedge clock) begin
        if (!we_was && pins.we_n && !pins.ce_n && pins.oe_n
            && low * CLK_NS >= WE_GLITCH_NS
            && busy == 0 && lock == 0) begin
            take(pins.addr, pins.dq_out); // Status from here
        end
        low = pins.we_n ? 0 : low + 1;
        we_was = pins.we_n;
        if (lock > 0) lock--;
        if (busy > 0) busy--;
        if (idle > 0) begin
            idle--;
            if (idle == 0) begin // Page from last load
                foreach (pa[i]) mem[{last_a[15:7], pa[i][6:0]}] = pd[i];
                pa.delete();
                pd.delete();
                armed = 1'b0;
                busy = WRITE_CYC;
                tog = 1'b0;
            end
        end
        if (!pins.ce_n && !pins.oe_n) begin
            if (oe_was) begin
                if (busy > 0) begin
                    tog = ~tog; // First read is one
                    rv = {~last_d[7], tog, last_d[5:0]};
                end else if (id_mode && pins.addr[14:1] == 14'h0000) begin
                    rv = pins.addr[0] ? PART_ID : MAKER_ID;
                end else begin
                    rv = mem[pins.addr];
                end
            end
            dq_in <= rv;
        end else begin
            dq_in <= ~dq_in; // Floating bus
        end
        oe_was = pins.oe_n;
    end
endmodule : eeprom_dev_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the EEPROM host controller
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top
    import eeprom_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h4E; // Arbitrary value
    localparam logic [7:0] PART = 8'hC3; // Arbitrary value
    typedef struct {
        op_t op;
        logic [15:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic g;
        logic id;
    } row_t;
    // Ordinary cases: operation, address, data, read byte, guard, id mode
    row_t rows [16] = '{
        '{OP_READ, 16'h0123, 8'h00, 8'hFF, 1'b0, 1'b0},
        '{OP_PLAIN_WRITE, 16'h0123, 8'hA5, 8'h00, 1'b0, 1'b0},
        '{OP_READ, 16'h0123, 8'h00, 8'hA5, 1'b0, 1'b0},
        '{OP_PROT_WRITE, 16'h1280, 8'h3C, 8'h00, 1'b1, 1'b0},
        '{OP_READ, 16'h1280, 8'h00, 8'h3C, 1'b1, 1'b0},
        '{OP_PLAIN_WRITE, 16'h0200, 8'h80, 8'h00, 1'b1, 1'b0},
        '{OP_READ, 16'h0200, 8'h00, 8'hFF, 1'b1, 1'b0},
        '{OP_ID_ENTRY, 16'h0000, 8'h00, 8'h00, 1'b1, 1'b1},
        '{OP_READ, 16'h0000, 8'h00, MAKER, 1'b1, 1'b1},
        '{OP_READ, 16'h0001, 8'h00, PART, 1'b1, 1'b1},
        '{OP_ID_EXIT, 16'h0000, 8'h00, 8'h00, 1'b1, 1'b0},
        '{OP_READ, 16'h1280, 8'h00, 8'h3C, 1'b1, 1'b0},
        '{OP_GUARD_OFF, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0},
        '{OP_READ, 16'h1280, 8'h00, 8'h3C, 1'b0, 1'b0},
        '{OP_PLAIN_WRITE, 16'h0200, 8'h66, 8'h00, 1'b0, 1'b0},
        '{OP_READ, 16'h0200, 8'h00, 8'h66, 1'b0, 1'b0}};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pins_t pins;
    logic [7:0] dq_in;
    logic [31:0] rd;
    logic [31:0] st;
    logic err_seen;
    int error_cnt = 0;
    int checked = 0;

    eeprom_host_ctrl #(.PAGE_WAIT_CYC(20)) i_dut (.clock(clock),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
    eeprom_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_dev (
        .clock(clock), .pins(pins), .dq_in(dq_in));

    initial begin
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Bus tasks and verdict
    // ------------------------------------------------------------------
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Start an operation, poll until done, keep status, clear done
    task automatic run_op(input op_t op, input logic [15:0] a,
                          input logic [7:0] d);
        int n;
        apb(1'b1, OFS_ADDR, {16'h0000, a});
        apb(1'b1, OFS_WDATA, {24'h000000, d});
        apb(1'b1, OFS_CTRL, {29'h00000000, op});
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            n++;
        end while (rd[ST_DONE] !== 1'b1 && n < 3000);
        st = rd;
        `CHK("done", 1'b1, st[ST_DONE])
        `CHK("busy", 1'b0, st[ST_BUSY])
        apb(1'b1, OFS_STATUS, 32'h0000_0002);
    endtask : run_op

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // Write strobe only with outputs off; controller never fights the bus
    always @(posedge clock) begin
        if (reset_n && !pins.we_n) `CHK("oe_at_we", 1'b1, pins.oe_n)
        if (reset_n && !pins.oe_n) `CHK("dq_oe", 1'b0, pins.dq_oe)
    end

    // Watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("BAD watchdog expired");
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        `CHK("pins_rst", PINS_IDLE, pins)
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            run_op(rows[i].op, rows[i].a, rows[i].d);
            `CHK("guard", rows[i].g, st[ST_GUARD])
            `CHK("id", rows[i].id, st[ST_ID])
            if (rows[i].op == OP_READ) begin
                `CHK("rdata", rows[i].rd, st[15:8])
            end
        end
        // Unmapped address refused
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        `CHK("slverr", 1'b1, err_seen)
        `CHK("unmapped", 32'h0000_0000, rd)
        // Reset in mid-series leaves a broken series; exit recovers
        apb(1'b1, OFS_ADDR, 32'h0000_1280);
        apb(1'b1, OFS_WDATA, 32'h0000_0077);
        apb(1'b1, OFS_CTRL, {29'h00000000, OP_PROT_WRITE});
        // Reset lands after two unlock loads, before the third is taken
        repeat (7) @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK("pins_mid", PINS_IDLE, pins)
        reset_n <= 1'b1;
        run_op(OP_ID_EXIT, 16'h0000, 8'h00);
        run_op(OP_READ, 16'h1280, 8'h00);
        `CHK("recover", 8'h3C, st[15:8])
        // Address writes while busy are ignored, so the read stays put
        apb(1'b1, OFS_CTRL, {29'h00000000, OP_READ});
        apb(1'b1, OFS_ADDR, 32'h0000_0555);
        apb(1'b0, OFS_ADDR, 32'h0000_0000);
        `CHK("busy_addr", 32'h0000_1280, rd)
        give_verdict();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
